// [hdl/gpm_pin_mux.sv]
// Purpose: Pin-function multiplexer and general-purpose port logic.
// Assumes: Pins are split into input, output and output-enable signals.
// Notes:   Pin reads always show the synchronised pin level.
//
// Operation
// - Free lower bits: input, output, irq, wake
// - Lower bits own pins unless switched
// - Fixed lower-pin peripheral function map
// - Upper bits only share listed pins
// - Of upper bits only bit 29 wakes, when enabled
// - Bit 20 never drives its pin
// - Six bus-control pins individually reassignable
// - Unused ROM selects become general purpose
// - Seven first-serial pins individually reassignable
// - Second serial: two-wire, infrared, full
// - Serial port slave, external clock in
// - Keypad only with card slot disabled
// - Two chip selects, space and direction
// - Panel upper nibble on lower pins
module gpm_pin_mux
   import gpm_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // Pins
   input  wire logic [31:0] gpio_pin_in,
   output logic      [31:0] gpio_pin_out,
   output logic      [31:0] gpio_pin_oe_out,
   // General-purpose configuration
   input  wire logic [31:0] gp_out_value_in,
   input  wire logic [31:0] gp_out_enable_in,
   input  wire logic [15:0] low_periph_sel_in,
   input  wire logic [15:0] low_irq_en_in,
   input  wire logic [15:0] low_wake_en_in,
   input  wire logic [15:0] up_periph_sel_in,
   input  wire logic        dcd_wake_en_in,
   output logic      [31:0] gp_read_out,
   output logic      [15:0] low_irq_out,
   output logic             wake_out,
   // Serial slave port
   output logic             ser_data_in_out,
   output logic             ser_clk_out,
   output logic             ser_frame_out,
   input  wire logic        ser_data_out_in,
   input  wire logic        frame_is_sysclk_in,
   input  wire logic        sysclk_in,
   // Second serial
   input  wire logic [1:0]  uart2_mode_in,
   input  wire logic        uart2_transmit_in,
   output logic             uart2_rx_out,
   input  wire logic        uart2_receive_pin_in,
   output logic             uart2_transmit_pin_out,
   input  wire logic        infrared_in,
   output logic             infrared_out,
   input  wire logic [1:0]  uart2_modem_out_in,
   output logic      [2:0]  uart2_modem_in_out,
   // Panel
   input  wire logic        panel_wide_in,
   input  wire logic [3:0]  panel_upper_in,
   // Upper shared pins: function side
   input  wire logic [15:0] up_func_out_in,
   input  wire logic [15:0] up_func_oe_in,
   output logic      [15:0] up_func_in_out,
   // Keypad and card slot
   input  wire logic        card_slot_enable_in,
   input  wire logic [7:0]  keypad_drive_in,
   input  wire logic [7:0]  keypad_sense_pin_in,
   output logic      [7:0]  keypad_sense_out,
   output logic      [7:0]  keypad_drive_out,
   output logic             keypad_active_out,
   // Chip select decode
   input  wire logic        bus_cycle_in,
   input  wire logic        bus_is_io_in,
   input  wire logic        bus_write_in,
   input  wire logic [21:0] bus_addr_in,
   input  wire logic [1:0]  cs_is_io_in,
   input  wire logic [1:0]  cs_qual_in_0,
   input  wire logic [1:0]  cs_qual_in_1,
   input  wire logic [21:0] cs_base_in_0,
   input  wire logic [21:0] cs_base_in_1,
   input  wire logic [21:0] cs_mask_in_0,
   input  wire logic [21:0] cs_mask_in_1
);
   logic [31:0] pin_sync;
   logic [7:0]  key_sync;
   logic [2:0]  ser_misc_sync;
   logic [15:0] pin_prev_reg;
   logic [15:0] pin_prev_next;
   logic [31:0] out_reg;
   logic [31:0] out_next;
   logic [31:0] oe_reg;
   logic [31:0] oe_next;
   logic [15:0] irq_reg;
   logic [15:0] irq_next;
   logic        wake_reg;
   logic        wake_next;
   logic [7:0]  key_drv_reg;
   logic [7:0]  key_drv_next;
   logic [1:0]  cs_hit;
   logic [1:0]  cs_qual [2];
   logic [21:0] cs_base [2];
   logic [21:0] cs_mask [2];
   logic [15:0] low_mode_oe;
   logic        key_on;
   logic [2:0]  arm_reg;
   logic [2:0]  arm_next;

   gpm_sync #(.WIDTH(32)) u_pin_sync
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (gpio_pin_in),
      .sync_out    (pin_sync)
   );

   gpm_sync #(.WIDTH(8)) u_key_sync
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    (keypad_sense_pin_in),
      .sync_out    (key_sync)
   );

   gpm_sync #(.WIDTH(3)) u_misc_sync
   (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .async_in    ({uart2_receive_pin_in, infrared_in, sysclk_in}),
      .sync_out    (ser_misc_sync)
   );

   assign cs_qual[0] = cs_qual_in_0;
   assign cs_qual[1] = cs_qual_in_1;
   assign cs_base[0] = cs_base_in_0;
   assign cs_base[1] = cs_base_in_1;
   assign cs_mask[0] = cs_mask_in_0;
   assign cs_mask[1] = cs_mask_in_1;

   // Chip select decode, active-high hit
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         cs_hit[i] = bus_cycle_in
            && (bus_is_io_in == cs_is_io_in[i])
            && (((bus_addr_in ^ cs_base[i]) & cs_mask[i]) == 22'h00_0000)
            && ((cs_qual[i] == GPM_QUAL_ANY)
               || ((cs_qual[i] == GPM_QUAL_READ) && !bus_write_in)
               || ((cs_qual[i] == GPM_QUAL_WRITE) && bus_write_in));
      end
   end

   assign key_on = !card_slot_enable_in;

   always_comb
   begin
      out_next = gp_out_value_in;
      oe_next  = GPM_RESET_ZERO;
      // Lower bits
      for (int i = 0; i < GPM_LOW_BITS; i++)
      begin
         if (!low_periph_sel_in[i])
         begin
            out_next[i] = gp_out_value_in[i];
            oe_next[i]  = gp_out_enable_in[i]
               && !low_irq_en_in[i] && !low_wake_en_in[i];
         end
      end
      // Peripheral functions ignore the output register
      if (low_periph_sel_in[GPM_SER_OUT])
      begin
         out_next[GPM_SER_OUT] = ser_data_out_in;
         oe_next[GPM_SER_OUT]  = 1'b1;
      end
      if (low_periph_sel_in[GPM_PROG_SELECT0_N_PIN])
      begin
         out_next[GPM_PROG_SELECT0_N_PIN] = !cs_hit[0];
         oe_next[GPM_PROG_SELECT0_N_PIN]  = 1'b1;
      end
      if (low_periph_sel_in[GPM_PROG_SELECT1_N_PIN])
      begin
         out_next[GPM_PROG_SELECT1_N_PIN] = !cs_hit[1];
         oe_next[GPM_PROG_SELECT1_N_PIN]  = 1'b1;
      end
      // Modem outputs on bits 6 and 7 in full mode only
      for (int m = 0; m < 2; m++)
      begin
         if (low_periph_sel_in[GPM_MODEM_LO + 1 + m])
         begin
            out_next[GPM_MODEM_LO + 1 + m] = uart2_modem_out_in[m];
            oe_next[GPM_MODEM_LO + 1 + m]  =
               (uart2_mode_in == GPM_U2_FULL);
         end
      end
      if (low_periph_sel_in[GPM_FRAME_PIN] && frame_is_sysclk_in)
      begin
         out_next[GPM_FRAME_PIN] = ser_misc_sync[0];
         oe_next[GPM_FRAME_PIN]  = 1'b1;
      end
      for (int p = 0; p < 4; p++)
      begin
         if (low_periph_sel_in[GPM_PANEL_LO + p])
         begin
            out_next[GPM_PANEL_LO + p] = panel_upper_in[p];
            oe_next[GPM_PANEL_LO + p]  = panel_wide_in;
         end
      end
      // Upper bits: a shared function or general purpose only
      for (int u = 0; u < GPM_UP_BITS; u++)
      begin
         if (up_periph_sel_in[u])
         begin
            out_next[GPM_LOW_BITS + u] = up_func_out_in[u];
            oe_next[GPM_LOW_BITS + u]  = up_func_oe_in[u];
         end
         else
         begin
            oe_next[GPM_LOW_BITS + u] = gp_out_enable_in[GPM_LOW_BITS + u];
         end
      end
      oe_next[GPM_LOW_BITS + GPM_UBE_PIN] = 1'b0;
      out_next[GPM_LOW_BITS + GPM_UBE_PIN] = 1'b0;
   end

   always_comb
   begin
      pin_prev_next = pin_sync[15:0];
      arm_next      = {arm_reg[1:0], 1'b1};
      irq_next      = GPM_RESET_HALF;
      wake_next     = 1'b0;
      for (int i = 0; i < GPM_LOW_BITS; i++)
      begin
         // No edge until both history stages hold real pin samples
         irq_next[i] = !low_periph_sel_in[i] && low_irq_en_in[i]
            && pin_sync[i] && !pin_prev_reg[i] && arm_reg[2];
         if (!low_periph_sel_in[i] && low_wake_en_in[i] && pin_sync[i])
         begin
            wake_next = 1'b1;
         end
      end
      if (dcd_wake_en_in && !pin_sync[GPM_LOW_BITS + GPM_DCD_PIN])
      begin
         wake_next = 1'b1;
      end
      // Synchronisers still hold reset zeros: no level is trusted yet
      if (!arm_reg[1])
      begin
         wake_next = 1'b0;
      end
      key_drv_next = key_on ? keypad_drive_in : GPM_RESET_BYTE;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         out_reg      <= GPM_RESET_ZERO;
         oe_reg       <= GPM_RESET_ZERO;
         irq_reg      <= GPM_RESET_HALF;
         wake_reg     <= 1'b0;
         pin_prev_reg <= GPM_RESET_HALF;
         key_drv_reg  <= GPM_RESET_BYTE;
         arm_reg      <= GPM_ARM_RESET;
      end
      else
      begin
         out_reg      <= out_next;
         oe_reg       <= oe_next;
         irq_reg      <= irq_next;
         wake_reg     <= wake_next;
         pin_prev_reg <= pin_prev_next;
         key_drv_reg  <= key_drv_next;
         arm_reg      <= arm_next;
      end
   end

   assign low_mode_oe      = oe_reg[15:0];
   assign gpio_pin_out     = out_reg;
   assign gpio_pin_oe_out  = {oe_reg[31:16], low_mode_oe};
   assign gp_read_out      = pin_sync;
   assign low_irq_out      = irq_reg;
   assign wake_out         = wake_reg;
   assign up_func_in_out   = pin_sync[31:16];
   // Slave serial port: clock comes from the master, frame too unless frame_is_sysclk_in
   assign ser_data_in_out  = low_periph_sel_in[GPM_SER_IN]
      && pin_sync[GPM_SER_IN];
   assign ser_clk_out      = low_periph_sel_in[GPM_SER_CLK]
      && pin_sync[GPM_SER_CLK];
   assign ser_frame_out    = low_periph_sel_in[GPM_FRAME_PIN]
      && !frame_is_sysclk_in && pin_sync[GPM_FRAME_PIN];
   // Second serial receive source by mode
   assign uart2_rx_out = (uart2_mode_in == GPM_U2_INFRARED)
      ? ser_misc_sync[1] : ser_misc_sync[2];
   assign uart2_transmit_pin_out = (uart2_mode_in == GPM_U2_INFRARED)
      ? 1'b1 : uart2_transmit_in;
   assign infrared_out = (uart2_mode_in == GPM_U2_INFRARED)
      && uart2_transmit_in;
   assign uart2_modem_in_out = {pin_sync[GPM_MODEM_LO + 4],
      pin_sync[GPM_MODEM_LO + 3], pin_sync[GPM_MODEM_LO]};
   assign keypad_sense_out  = key_on ? key_sync : 8'h00;
   assign keypad_drive_out  = key_drv_reg;
   assign keypad_active_out = key_on;
endmodule

// [hdl/gpm_pkg.sv]
// Purpose: Constants shared by the pin-function multiplexer.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes:   Pin functions are selected per bit by plain control ports.
package gpm_pkg;
   localparam int GPM_BITS       = 32;
   localparam int GPM_LOW_BITS   = 16;
   localparam int GPM_UP_BITS    = 16;
   // Lower pin positions
   localparam int GPM_SER_IN     = 0;
   localparam int GPM_SER_OUT    = 1;
   localparam int GPM_SER_CLK    = 2;
   localparam int GPM_PROG_SELECT0_N_PIN   = 3;
   localparam int GPM_MODEM_LO   = 5;
   localparam int GPM_FRAME_PIN  = 10;
   localparam int GPM_PROG_SELECT1_N_PIN   = 11;
   localparam int GPM_PANEL_LO   = 12;
   // Upper pin positions, relative to bit 16
   localparam int GPM_UBE_PIN    = 4;
   localparam int GPM_DCD_PIN    = 13;
   localparam int GPM_BUSCTL_LO  = 0;
   localparam int GPM_ROMSEL_LO  = 6;
   localparam int GPM_UART1_LO   = 9;
   // Modes of a lower general-purpose bit
   typedef enum logic [3:0]
   {
      GPM_MODE_IN   = 4'h1,
      GPM_MODE_OUT  = 4'h2,
      GPM_MODE_IRQ  = 4'h4,
      GPM_MODE_WAKE = 4'h8
   } gpm_mode_e;
   // Second serial pin modes
   localparam logic [1:0] GPM_U2_TWO_WIRE = 2'h0;
   localparam logic [1:0] GPM_U2_INFRARED = 2'h1;
   localparam logic [1:0] GPM_U2_FULL     = 2'h2;
   // Chip select qualifiers
   localparam logic [1:0] GPM_QUAL_ANY    = 2'h0;
   localparam logic [1:0] GPM_QUAL_READ   = 2'h1;
   localparam logic [1:0] GPM_QUAL_WRITE  = 2'h2;
   localparam logic [31:0] GPM_RESET_ZERO = 32'h0000_0000;
   localparam logic [15:0] GPM_RESET_HALF = 16'h0000;
   localparam logic [7:0]  GPM_RESET_BYTE = 8'h00;
   localparam logic [2:0]  GPM_ARM_RESET  = 3'h0;
endpackage

// [hdl/gpm_sync.sv]
// Purpose: Two-stage synchroniser for a vector of pins.
// Assumes: Inputs asynchronous to core_clk_in.
// Notes:   First stage is read only by the second stage.
module gpm_sync
   import gpm_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule

// [sim/gpm_pin_mux_bench.sv]
// Purpose: Directed tests of the pin multiplexer.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Far-side pin levels come from gpm_pins_model.
module gpm_pin_mux_bench
   import gpm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0, rst_in = 1'b1;
   logic [31:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe_out, gp_read_out;
   logic [31:0] gp_out_value_in, gp_out_enable_in, ext;
   logic [15:0] low_periph_sel_in, low_irq_en_in, low_wake_en_in;
   logic [15:0] up_periph_sel_in, up_func_out_in, up_func_oe_in;
   logic [15:0] low_irq_out, up_func_in_out;
   logic dcd_wake_en_in, wake_out, ser_data_in_out, ser_clk_out;
   logic ser_frame_out, ser_data_out_in, frame_is_sysclk_in, sysclk_in;
   logic [1:0] uart2_mode_in, uart2_modem_out_in, cs_is_io_in;
   logic [1:0] cs_qual_in_0, cs_qual_in_1;
   logic uart2_transmit_in, uart2_rx_out, uart2_receive_pin_in;
   logic uart2_transmit_pin_out, infrared_in, infrared_out;
   logic [2:0] uart2_modem_in_out;
   logic panel_wide_in, card_slot_enable_in, keypad_active_out;
   logic [3:0] panel_upper_in;
   logic [7:0] keypad_drive_in, keypad_sense_pin_in, keypad_sense_out;
   logic [7:0] keypad_drive_out;
   logic bus_cycle_in, bus_is_io_in, bus_write_in, hit;
   logic [21:0] bus_addr_in, cs_base_in_0, cs_base_in_1;
   logic [21:0] cs_mask_in_0, cs_mask_in_1;
   int n_fail = 0, n_tests = 0, k;

   always #25 core_clk_in = ~core_clk_in;

   gpm_pin_mux u_gpm_pin_mux (.*);
   gpm_pins_model u_gpm_pins_model (.dev_out_in(gpio_pin_out),
      .dev_oe_in(gpio_pin_oe_out), .ext_level_in(ext),
      .wire_out(gpio_pin_in));

   task automatic tk(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      {gp_out_value_in, gp_out_enable_in, ext, low_periph_sel_in,
       low_irq_en_in, low_wake_en_in, up_periph_sel_in, up_func_out_in,
       up_func_oe_in, dcd_wake_en_in, ser_data_out_in, frame_is_sysclk_in,
       sysclk_in, uart2_mode_in, uart2_modem_out_in, cs_is_io_in,
       cs_qual_in_0, cs_qual_in_1, uart2_transmit_in, uart2_receive_pin_in,
       infrared_in, panel_wide_in, card_slot_enable_in, panel_upper_in,
       keypad_drive_in, keypad_sense_pin_in, bus_cycle_in, bus_is_io_in,
       bus_write_in, bus_addr_in, cs_base_in_0, cs_base_in_1, cs_mask_in_0,
       cs_mask_in_1} = '0;
      tk(3);
      rst_in = 1'b0;
      chk(gpio_pin_oe_out, 32'h0000_0000);
      gp_out_enable_in = 32'hFFFF_FFFF;
      gp_out_value_in = 32'hA5A5_A5A5;
      tk(1);
      chk(gpio_pin_oe_out, 32'hFFEF_FFFF);
      chk(gpio_pin_out & 32'hFFEF_FFFF, 32'hA5A5_A5A5);
      gp_out_enable_in = 32'h0000_0000;
      ext = 32'h5A5A_0F0F;
      tk(3);
      chk(gp_read_out, ext);
      low_periph_sel_in = 16'h0407;
      gp_out_enable_in = 32'h0000_0002;
      gp_out_value_in = 32'h0000_0002;
      ext = 32'h0000_0405;
      tk(3);
      chk(32'({ser_frame_out, ser_clk_out, ser_data_in_out,
               gpio_pin_out[1]}), 32'hE);
      chk(gpio_pin_oe_out & 32'h0000_0405, 32'h0000_0000);
      ser_data_out_in = 1'b1;
      tk(1);
      chk(32'(gpio_pin_out[1]), 32'h1);
      low_periph_sel_in = 16'h0808;
      cs_is_io_in = 2'b01;
      cs_base_in_0 = 22'h00_1234;
      cs_mask_in_0 = 22'h3F_FFFF;
      cs_base_in_1 = 22'h20_0000;
      cs_mask_in_1 = 22'h30_0000;
      bus_cycle_in = 1'b1;
      for (k = 0; k < 12; k++)
      begin
         cs_qual_in_0 = 2'(k % 3);
         cs_qual_in_1 = 2'(k % 3);
         bus_write_in = 1'((k / 3) % 2);
         bus_is_io_in = 1'(k / 6);
         bus_addr_in = bus_is_io_in ? 22'h00_1234 : 22'h21_0000;
         hit = (k % 3 == 0) || (k % 3 == 1 && !bus_write_in)
            || (k % 3 == 2 && bus_write_in);
         tk(1);
         chk(32'({gpio_pin_out[11], gpio_pin_out[3]}),
             32'({!(!bus_is_io_in && hit), !(bus_is_io_in && hit)}));
      end
      bus_addr_in = 22'h00_1235;
      tk(1);
      chk(32'({gpio_pin_out[11], gpio_pin_out[3]}), 32'h3);
      low_periph_sel_in = 16'hF000;
      panel_wide_in = 1'b1;
      panel_upper_in = 4'hA;
      tk(1);
      chk(32'(gpio_pin_out[15:12]), 32'hA);
      low_periph_sel_in = 16'h0000;
      low_irq_en_in = 16'h0010;
      ext = 32'h0000_0000;
      tk(4);
      ext[4] = 1'b1;
      k = 0;
      repeat (8)
      begin
         tk(1);
         if (low_irq_out[4] === 1'b1)
            k++;
      end
      chk(32'(k), 32'h1);
      low_irq_en_in = 16'h0000;
      ext = 32'h2000_0000;
      dcd_wake_en_in = 1'b1;
      tk(4);
      chk(32'(wake_out), 32'h0);
      ext[29] = 1'b0;
      k = 0;
      while (wake_out !== 1'b1 && k < 8)
      begin
         tk(1);
         k++;
      end
      if (k == 8)
      begin
         n_fail++;
         results();
      end
      dcd_wake_en_in = 1'b0;
      tk(2);
      chk(32'(wake_out), 32'h0);
      card_slot_enable_in = 1'b1;
      keypad_drive_in = 8'h5A;
      keypad_sense_pin_in = 8'h3C;
      tk(2);
      chk(32'({keypad_active_out, keypad_drive_out}), 32'h0);
      chk(32'(keypad_sense_out), 32'h0);
      card_slot_enable_in = 1'b0;
      tk(2);
      chk(32'({keypad_active_out, keypad_drive_out}), 32'h15A);
      chk(32'(keypad_sense_out), 32'h3C);
      uart2_transmit_in = 1'b1;
      uart2_mode_in = GPM_U2_INFRARED;
      tk(1);
      chk(32'(infrared_out), 32'h1);
      uart2_mode_in = GPM_U2_TWO_WIRE;
      tk(1);
      chk(32'(uart2_transmit_pin_out), 32'h1);
      up_periph_sel_in = 16'h0241;
      up_func_out_in = 16'hFFFF;
      up_func_oe_in = 16'hFFFF;
      gp_out_enable_in = 32'hFFFF_0002;
      tk(1);
      chk(gpio_pin_oe_out & 32'hFFFF_0000, 32'hFFEF_0000);
      chk(gpio_pin_out & 32'hFFFF_0000, 32'h0241_0000);
      tk(2);
      chk(32'(up_func_in_out), 32'h0241);
      low_periph_sel_in = 16'h07E0;
      uart2_mode_in = GPM_U2_FULL;
      uart2_modem_out_in = 2'b10;
      frame_is_sysclk_in = 1'b1;
      sysclk_in = 1'b1;
      uart2_receive_pin_in = 1'b1;
      ext = 32'h0000_0320;
      tk(3);
      chk(32'({gpio_pin_oe_out[9:5], gpio_pin_out[7:6]}), 32'h1A);
      chk(32'({ser_frame_out, gpio_pin_oe_out[10],
               gpio_pin_out[10]}), 32'h3);
      chk(32'({uart2_modem_in_out, uart2_rx_out}), 32'hF);
      uart2_mode_in = GPM_U2_INFRARED;
      tk(1);
      chk(32'({gpio_pin_oe_out[7:6], uart2_rx_out}), 32'h0);
      results();
   end
endmodule

// [sim/gpm_pin_mux_sva.sv]
// Purpose: Port checks for the pin multiplexer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every gpm_pin_mux instance.
module gpm_pin_mux_sva
   import gpm_pkg::*;
(
   input wire logic        core_clk_in,
   input wire logic        rst_in,
   input wire logic [31:0] gpio_pin_in,
   input wire logic [31:0] gpio_pin_out,
   input wire logic [31:0] gpio_pin_oe_out,
   input wire logic [31:0] gp_out_enable_in,
   input wire logic [15:0] low_periph_sel_in,
   input wire logic [15:0] low_irq_en_in,
   input wire logic [15:0] low_wake_en_in,
   input wire logic [31:0] gp_read_out,
   input wire logic [15:0] low_irq_out,
   input wire logic        dcd_wake_en_in,
   input wire logic        wake_out,
   input wire logic        card_slot_enable_in,
   input wire logic        keypad_active_out,
   input wire logic [1:0]  uart2_mode_in,
   input wire logic        uart2_transmit_in,
   input wire logic        infrared_out,
   input wire logic        ser_data_out_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] free_lo;
   logic [15:0] free_en;
   assign free_lo = ~(low_periph_sel_in | low_irq_en_in | low_wake_en_in);
   assign free_en = gp_out_enable_in[15:0] & free_lo;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   no_drive_20_a: assert property (!gpio_pin_oe_out[20])
      else $error("pin 20 output enable set");
   gp_oe_follow_a: assert property (1'b1 |=>
      (gpio_pin_oe_out[15:0] & $past(free_lo)) == $past(free_en))
      else $error("free lower bit enable mismatch");
   periph_out_a: assert property (low_periph_sel_in[1] |=>
      gpio_pin_out[1] == $past(ser_data_out_in))
      else $error("serial data pin not from serial port");
   read_lat_a: assert property (1'b1 |-> ##2
      gp_read_out == $past(gpio_pin_in, 2))
      else $error("pin read latency wrong");
   irq_cause_a: assert property ((!rst_in)[*5] ##0 low_irq_out[4] |->
      $past(gpio_pin_in[4], 3) && !$past(gpio_pin_in[4], 4))
      else $error("irq pulse without pin rise");
   irq_pulse_a: assert property (low_irq_out[4] |=> !low_irq_out[4])
      else $error("irq pulse longer than one cycle");
   wake_off_a: assert property (
      (!dcd_wake_en_in && low_wake_en_in == 16'h0000)[*3] |=> !wake_out)
      else $error("wake without enabled source");
   keypad_gate_a: assert property (1'b1 |->
      keypad_active_out == !card_slot_enable_in)
      else $error("keypad active with card slot enabled");
   modem_oe_a: assert property ((low_periph_sel_in[6]
      && uart2_mode_in != GPM_U2_FULL) |=> !gpio_pin_oe_out[6])
      else $error("modem output driven outside full mode");
   ir_tx_a: assert property (uart2_mode_in == GPM_U2_INFRARED |->
      infrared_out == uart2_transmit_in)
      else $error("infrared output not from transmitter");
   cover property (low_irq_out[4]);
   cover property (wake_out);
   cover property (keypad_active_out);
   cover property (uart2_mode_in == GPM_U2_FULL && gpio_pin_oe_out[6]);
endmodule

bind gpm_pin_mux gpm_pin_mux_sva u_gpm_pin_mux_sva (.*);

// [sim/gpm_pins_model.sv]
// Purpose: Devices on the far side of the pins.
// Assumes: A device drives each pin that the mux leaves released.
// Notes:   ext_level_in is what the devices put on released pins.
module gpm_pins_model
(
   input  wire logic [31:0] dev_out_in,
   input  wire logic [31:0] dev_oe_in,
   input  wire logic [31:0] ext_level_in,
   output logic      [31:0] wire_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Serial clock and frame come from the outside master
   assign wire_out = (dev_out_in & dev_oe_in)
                   | (ext_level_in & ~dev_oe_in);
endmodule
